// >>> inc/gpz_pkg.sv
// Package of constants for general-purpose ports zero to three
package gpz_pkg;

  // ----------------------------------------------------------------
  // Port widths
  // ----------------------------------------------------------------
  localparam int unsigned PORT0_WIDTH = 7;
  localparam int unsigned PORT1_WIDTH = 8;
  localparam int unsigned PORT2_WIDTH = 8;
  localparam int unsigned PORT3_WIDTH = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  // Direction bit one means input
  localparam logic [7:0] DIR_RESET    = 8'hFF;
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  // Analog configuration bit one means analog input
  localparam logic [7:0] ANALOG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Special bit positions of port 0
  // ----------------------------------------------------------------
  localparam logic [6:0] PORT0_TTL_CAPABLE = 7'h18;
  localparam logic [6:0] PORT0_OD_CAPABLE  = 7'h1C;

endpackage : gpz_pkg

// >>> src/gpz_port_bits.sv
// One generic port: latch, direction, pull-up, open-drain and read-back
`timescale 1ns/100ps
module gpz_port_bits #(
  parameter int unsigned WIDTH   = 8,
  parameter logic [7:0]  PU_MASK = 8'hFF,
  parameter logic [7:0]  OD_MASK = 8'h00
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // Software side
  input  wire logic             latch_we_i,
  input  wire logic             dir_we_i,
  input  wire logic             pullup_we_i,
  input  wire logic             od_we_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [WIDTH-1:0] dig_enable_i,
  output logic      [WIDTH-1:0] rdata_o,
  output logic      [WIDTH-1:0] latch_o,
  output logic      [WIDTH-1:0] dir_o,
  output logic      [WIDTH-1:0] pullup_en_o,
  output logic      [WIDTH-1:0] od_sel_o,
  // Pin side
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] pin_o,
  output logic      [WIDTH-1:0] pin_oe_o,
  output logic      [WIDTH-1:0] pin_pullup_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("port width must be 1 to 8");
  end

  logic [WIDTH-1:0] latch_q, latch_d;
  logic [WIDTH-1:0] dir_q, dir_d;
  logic [WIDTH-1:0] pu_q, pu_d;
  logic [WIDTH-1:0] od_q, od_d;

  // Next-state of control registers; absent options stay zero
  always_comb
  begin
    latch_d = latch_we_i ? wdata_i : latch_q;
    dir_d   = dir_we_i ? wdata_i : dir_q;
    pu_d    = pullup_we_i ? (wdata_i & PU_MASK[WIDTH-1:0]) : pu_q;
    od_d    = od_we_i ? (wdata_i & OD_MASK[WIDTH-1:0]) : od_q;
  end

  // Registers; reset forces every bit to input
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      latch_q <= gpz_pkg::LATCH_RESET[WIDTH-1:0];
      dir_q   <= gpz_pkg::DIR_RESET[WIDTH-1:0];
      pu_q    <= gpz_pkg::PULLUP_RESET[WIDTH-1:0];
      od_q    <= gpz_pkg::MODE_RESET[WIDTH-1:0];
    end
    else
    begin
      latch_q <= latch_d;
      dir_q   <= dir_d;
      pu_q    <= pu_d;
      od_q    <= od_d;
    end
  end

  // Pin drive; open-drain bits only ever pull low
  always_comb
  begin
    pin_o        = latch_q;
    pin_oe_o     = ~dir_q & dig_enable_i & ~(od_q & latch_q);
    pin_pullup_o = dir_q & pu_q & dig_enable_i;
    rdata_o      = (dir_q & pin_i) | (~dir_q & latch_q);
  end

  assign latch_o     = latch_q;
  assign dir_o       = dir_q;
  assign pullup_en_o = pu_q;
  assign od_sel_o    = od_q;

endmodule : gpz_port_bits

// >>> src/gpz_ports.sv
// Top of general-purpose ports zero to three
//
// Overview of operation
// RQ1: Port 0 has seven bits, each with latch and own direction bit.
// RQ2: Port 0 input bits get pull-up only when their enable bit is set.
// RQ3: Port 0 bits 3 and 4 choose normal or TTL input buffer per bit.
// RQ4: Port 0 bits 2 to 4 become open-drain when their select bit is set.
// RQ5: Reset makes every bit of ports 0, 1 and 3 an input.
// RQ6: Port 1 has eight bits with latches and per-bit direction.
// RQ7: Port 1 input bits get pull-up only when their enable bit is set.
// RQ8: Port 2 has eight bits, no pull-up, shared with analog channels.
// RQ9: Port 2 digital and input direction gives a digital input.
// RQ10: Port 2 digital and output direction drives the latch value.
// RQ11: Port 2 analog input converts only when channel select names it.
// RQ12: Software places digital bits low and analog bits high on port 2.
// RQ13: Reset makes all port 2 pins digital inputs.
// RQ14: Port 3 has two bits with latches and per-bit direction.
// RQ15: Port 3 input bits get pull-up only when their enable bit is set.
// RQ16: Software clears timer channels 0, 5, 6 before port 0 use.
// RQ17: Software clears timer channels 1 and 2 before port 1 use.
// RQ18: Software clears timer channel 3 before port 3 bit 1 use.
// RQ19: Software clears both clock-out enables before port 1 bit 5 use.
// RQ20: Software clears one-hertz output enable before port 3 bit 0 use.
// RQ21: Reads give pin level for inputs, latch for outputs; writes hit latch.
`timescale 1ns/100ps
module gpz_ports (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // Shared write data
  input  wire logic [7:0] wdata_i,
  // Port 0 software side
  input  wire logic       port0_latch_we_i,
  input  wire logic       port0_direction_we_i,
  input  wire logic       port0_pullup_enable_we_i,
  input  wire logic       port0_input_buffer_select_we_i,
  input  wire logic       port0_opendrain_select_we_i,
  output logic      [6:0] port0_rdata_o,
  output logic      [6:0] port0_direction_o,
  output logic      [6:0] port0_input_buffer_select_o,
  output logic      [6:0] port0_opendrain_select_o,
  // Port 0 pins
  input  wire logic [6:0] port0_pin_i,
  input  wire logic [6:0] port0_pin_ttl_i,
  output logic      [6:0] port0_pin_o,
  output logic      [6:0] port0_pin_oe_o,
  output logic      [6:0] port0_pullup_o,
  output logic      [6:0] port0_ttl_buffer_o,
  // Port 1 software side
  input  wire logic       port1_latch_we_i,
  input  wire logic       port1_direction_we_i,
  input  wire logic       port1_pullup_enable_we_i,
  output logic      [7:0] port1_rdata_o,
  output logic      [7:0] port1_direction_o,
  // Port 1 pins
  input  wire logic [7:0] port1_pin_i,
  output logic      [7:0] port1_pin_o,
  output logic      [7:0] port1_pin_oe_o,
  output logic      [7:0] port1_pullup_o,
  // Port 2 software side
  input  wire logic       port2_latch_we_i,
  input  wire logic       port2_direction_we_i,
  input  wire logic       analog_pin_configuration_we_i,
  input  wire logic [2:0] converter_channel_select_i,
  output logic      [7:0] port2_rdata_o,
  output logic      [7:0] port2_direction_o,
  output logic      [7:0] analog_pin_configuration_o,
  output logic            analog_convert_enable_o,
  output logic            analog_setting_error_o,
  // Port 2 pins
  input  wire logic [7:0] port2_pin_i,
  output logic      [7:0] port2_pin_o,
  output logic      [7:0] port2_pin_oe_o,
  output logic      [7:0] port2_analog_path_o,
  // Port 3 software side
  input  wire logic       port3_latch_we_i,
  input  wire logic       port3_direction_we_i,
  input  wire logic       port3_pullup_enable_we_i,
  output logic      [1:0] port3_rdata_o,
  output logic      [1:0] port3_direction_o,
  // Port 3 pins
  input  wire logic [1:0] port3_pin_i,
  output logic      [1:0] port3_pin_o,
  output logic      [1:0] port3_pin_oe_o,
  output logic      [1:0] port3_pullup_o
);

  // ----------------------------------------------------------------
  // Port 0
  // ----------------------------------------------------------------
  logic [6:0] p0_pin_sel;
  logic [6:0] p0_latch;
  logic [6:0] p0_pu;
  logic [6:0] ibs_q, ibs_d;

  // Input buffer select exists only on the TTL-capable bits
  always_comb
  begin
    ibs_d = port0_input_buffer_select_we_i ?
            (wdata_i[6:0] & gpz_pkg::PORT0_TTL_CAPABLE) : ibs_q; // [RQ3]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      ibs_q <= gpz_pkg::MODE_RESET[6:0];
    else
      ibs_q <= ibs_d;
  end

  // Chosen buffer feeds the read path per bit
  assign p0_pin_sel = (ibs_q & port0_pin_ttl_i) | (~ibs_q & port0_pin_i); // [RQ3]
  assign port0_ttl_buffer_o          = ibs_q;
  assign port0_input_buffer_select_o = ibs_q;

  // Seven bits, pull-up on all, open-drain on bits 2 to 4
  gpz_port_bits #(
    .WIDTH   (gpz_pkg::PORT0_WIDTH),
    .PU_MASK (8'h7F),
    .OD_MASK ({1'b0, gpz_pkg::PORT0_OD_CAPABLE})
  ) u_port0 ( // [RQ1] [RQ2] [RQ4] [RQ5] [RQ21]
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .latch_we_i   (port0_latch_we_i),
    .dir_we_i     (port0_direction_we_i),
    .pullup_we_i  (port0_pullup_enable_we_i),
    .od_we_i      (port0_opendrain_select_we_i),
    .wdata_i      (wdata_i[6:0]),
    .dig_enable_i (7'h7F),
    .rdata_o      (port0_rdata_o),
    .latch_o      (p0_latch),
    .dir_o        (port0_direction_o),
    .pullup_en_o  (p0_pu),
    .od_sel_o     (port0_opendrain_select_o),
    .pin_i        (p0_pin_sel),
    .pin_o        (port0_pin_o),
    .pin_oe_o     (port0_pin_oe_o),
    .pin_pullup_o (port0_pullup_o)
  );

  // ----------------------------------------------------------------
  // Port 1
  // ----------------------------------------------------------------
  gpz_port_bits #(
    .WIDTH   (gpz_pkg::PORT1_WIDTH),
    .PU_MASK (8'hFF),
    .OD_MASK (8'h00)
  ) u_port1 ( // [RQ6] [RQ7] [RQ5] [RQ21]
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .latch_we_i   (port1_latch_we_i),
    .dir_we_i     (port1_direction_we_i),
    .pullup_we_i  (port1_pullup_enable_we_i),
    .od_we_i      (1'b0),
    .wdata_i      (wdata_i),
    .dig_enable_i (8'hFF),
    .rdata_o      (port1_rdata_o),
    .latch_o      (),
    .dir_o        (port1_direction_o),
    .pullup_en_o  (),
    .od_sel_o     (),
    .pin_i        (port1_pin_i),
    .pin_o        (port1_pin_o),
    .pin_oe_o     (port1_pin_oe_o),
    .pin_pullup_o (port1_pullup_o)
  );

  // ----------------------------------------------------------------
  // Port 2 with analog sharing
  // ----------------------------------------------------------------
  logic [7:0] apc_q, apc_d;
  logic [7:0] p2_dig_en;
  logic [7:0] p2_rdata_raw;

  // Analog configuration register, one bit per pin
  always_comb
  begin
    apc_d = analog_pin_configuration_we_i ? wdata_i : apc_q;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      apc_q <= gpz_pkg::ANALOG_RESET; // [RQ13]
    else
      apc_q <= apc_d;
  end

  // Analog pins never drive, even if software breaks the setting
  assign p2_dig_en = ~apc_q; // [RQ9] [RQ10]

  // No pull-up on this port
  gpz_port_bits #(
    .WIDTH   (gpz_pkg::PORT2_WIDTH),
    .PU_MASK (8'h00),
    .OD_MASK (8'h00)
  ) u_port2 ( // [RQ8] [RQ13] [RQ21]
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .latch_we_i   (port2_latch_we_i),
    .dir_we_i     (port2_direction_we_i),
    .pullup_we_i  (1'b0),
    .od_we_i      (1'b0),
    .wdata_i      (wdata_i),
    .dig_enable_i (p2_dig_en),
    .rdata_o      (p2_rdata_raw),
    .latch_o      (),
    .dir_o        (port2_direction_o),
    .pullup_en_o  (),
    .od_sel_o     (),
    .pin_i        (port2_pin_i),
    .pin_o        (port2_pin_o),
    .pin_oe_o     (port2_pin_oe_o),
    .pin_pullup_o ()
  );

  // Analog bits read as zero; digital bits read as usual
  assign port2_rdata_o = p2_rdata_raw & ~apc_q; // [RQ9]
  assign analog_pin_configuration_o = apc_q;
  assign port2_analog_path_o = apc_q & port2_direction_o; // [RQ11]
  // Conversion only of the named channel when it is an analog input
  assign analog_convert_enable_o = port2_analog_path_o[converter_channel_select_i]; // [RQ11]
  // Flags the prohibited analog-plus-output combination
  assign analog_setting_error_o = |(apc_q & ~port2_direction_o); // [RQ11]

  // ----------------------------------------------------------------
  // Port 3
  // ----------------------------------------------------------------
  gpz_port_bits #(
    .WIDTH   (gpz_pkg::PORT3_WIDTH),
    .PU_MASK (8'h03),
    .OD_MASK (8'h00)
  ) u_port3 ( // [RQ14] [RQ15] [RQ5] [RQ21]
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .latch_we_i   (port3_latch_we_i),
    .dir_we_i     (port3_direction_we_i),
    .pullup_we_i  (port3_pullup_enable_we_i),
    .od_we_i      (1'b0),
    .wdata_i      (wdata_i[1:0]),
    .dig_enable_i (2'h3),
    .rdata_o      (port3_rdata_o),
    .latch_o      (),
    .dir_o        (port3_direction_o),
    .pullup_en_o  (),
    .od_sel_o     (),
    .pin_i        (port3_pin_i),
    .pin_o        (port3_pin_o),
    .pin_oe_o     (port3_pin_oe_o),
    .pin_pullup_o (port3_pullup_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_p0_pullup_gate: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ2]
    port0_pullup_o == (p0_pu & port0_direction_o)) else $error("p0 pullup");
  chk_p0_ttl_bits: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ3]
    (ibs_q & 7'h67) == 7'h00) else $error("ttl bit outside 3..4");
  chk_p0_od_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ4]
    (port0_pin_oe_o & port0_opendrain_select_o & p0_latch) == 7'h00)
    else $error("open drain drove high");
  // Looks one cycle past a sampled reset, so start-up needs no history
  chk_reset_inputs: assert property (@(posedge clk_sys_i) // [RQ5]
    reset_i |=> (port0_pin_oe_o == 7'h00 && port1_pin_oe_o == 8'h00
    && port3_pin_oe_o == 2'h0)) else $error("drive after reset");
  chk_p1_latch_write: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ6]
    port1_latch_we_i ##1 (port1_direction_o == 8'h00) |-> port1_rdata_o == $past(wdata_i))
    else $error("p1 latch readback");
  chk_p1_pullup_out: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ7]
    (port1_pullup_o & ~port1_direction_o) == 8'h00) else $error("p1 pullup on output");
  chk_p2_analog_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ10]
    (port2_pin_oe_o & apc_q) == 8'h00) else $error("analog pin driven");
  chk_p2_reset_state: assert property (@(posedge clk_sys_i) // [RQ13]
    reset_i |=> (apc_q == 8'h00 && port2_direction_o == 8'hFF))
    else $error("p2 reset state");
  chk_p3_read_input: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RQ21]
    port3_direction_o == 2'h3 |-> port3_rdata_o == port3_pin_i)
    else $error("p3 read input");

endmodule : gpz_ports

// >>> bench/gpz_pin_board.sv
// Board model that drives, pulls and senses the pins of one port
`timescale 1ns/100ps
module gpz_pin_board #(
  parameter int unsigned W = 8
) (
  // Clock
  input  wire logic         clk_sys_i,
  // Device pin side
  input  wire logic [W-1:0] pin_o_i,
  input  wire logic [W-1:0] pin_oe_i,
  input  wire logic [W-1:0] pullup_i,
  // Board drivers
  input  wire logic [W-1:0] drv_en_i,
  input  wire logic [W-1:0] drv_val_i,
  input  wire logic [W-1:0] marg_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] ttl_o
);
  logic [W-1:0] last_q = '0;

  // Device drive wins, then board, then pull-up; a floating pin flips every
  // cycle so that an unpulled read can never match by luck
  assign lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_en_i & drv_val_i)
               | (~pin_oe_i & ~drv_en_i & (pullup_i | ~last_q));
  // Marginal level reads inverted on the TTL buffer only
  assign ttl_o = lvl_o ^ marg_i;

  // Last seen level
  always_ff @(posedge clk_sys_i)
  begin
    last_q <= lvl_o;
  end
endmodule : gpz_pin_board

// >>> bench/gpz_ports_bench.sv
// Self-checking bench for general-purpose ports zero to three
`timescale 1ns/100ps
module gpz_ports_bench;
  logic       clk_sys_i;
  logic       reset_i;
  logic [7:0] wdata;
  logic [13:0] we;
  logic [2:0] ch;
  logic [7:0] bd_en;
  logic [7:0] bd_val;
  logic [6:0] marg;
  logic [6:0] p0_rd, p0_dir, p0_ibs, p0_od, p0_po, p0_oe, p0_pu, p0_lv, p0_tl, p0_tb;
  logic [7:0] p1_rd, p1_dir, p1_po, p1_oe, p1_pu, p1_lv;
  logic [7:0] p2_rd, p2_dir, p2_ac, p2_po, p2_oe, p2_ap, p2_lv;
  logic       p2_cv, p2_er;
  logic [1:0] p3_rd, p3_dir, p3_po, p3_oe, p3_pu, p3_lv;
  int         error_cnt = 0;
  int         compares = 0;

  // ----------------------------------------------------------------
  // Design and board models
  // ----------------------------------------------------------------
  gpz_ports gpz_ports_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .wdata_i(wdata),
    .port0_latch_we_i(we[0]), .port0_direction_we_i(we[1]),
    .port0_pullup_enable_we_i(we[2]), .port0_input_buffer_select_we_i(we[3]),
    .port0_opendrain_select_we_i(we[4]), .port0_rdata_o(p0_rd),
    .port0_direction_o(p0_dir), .port0_input_buffer_select_o(p0_ibs),
    .port0_opendrain_select_o(p0_od), .port0_pin_i(p0_lv), .port0_pin_ttl_i(p0_tl),
    .port0_pin_o(p0_po), .port0_pin_oe_o(p0_oe), .port0_pullup_o(p0_pu),
    .port0_ttl_buffer_o(p0_tb), .port1_latch_we_i(we[5]), .port1_direction_we_i(we[6]),
    .port1_pullup_enable_we_i(we[7]), .port1_rdata_o(p1_rd), .port1_direction_o(p1_dir),
    .port1_pin_i(p1_lv), .port1_pin_o(p1_po), .port1_pin_oe_o(p1_oe),
    .port1_pullup_o(p1_pu), .port2_latch_we_i(we[8]), .port2_direction_we_i(we[9]),
    .analog_pin_configuration_we_i(we[10]), .converter_channel_select_i(ch),
    .port2_rdata_o(p2_rd), .port2_direction_o(p2_dir), .analog_pin_configuration_o(p2_ac),
    .analog_convert_enable_o(p2_cv), .analog_setting_error_o(p2_er),
    .port2_pin_i(p2_lv), .port2_pin_o(p2_po), .port2_pin_oe_o(p2_oe),
    .port2_analog_path_o(p2_ap), .port3_latch_we_i(we[11]), .port3_direction_we_i(we[12]),
    .port3_pullup_enable_we_i(we[13]), .port3_rdata_o(p3_rd), .port3_direction_o(p3_dir),
    .port3_pin_i(p3_lv), .port3_pin_o(p3_po), .port3_pin_oe_o(p3_oe), .port3_pullup_o(p3_pu)
  );
  gpz_pin_board #(.W(7)) gpz_pin_board_inst0 (.clk_sys_i(clk_sys_i), .pin_o_i(p0_po),
    .pin_oe_i(p0_oe), .pullup_i(p0_pu), .drv_en_i(bd_en[6:0]), .drv_val_i(bd_val[6:0]),
    .marg_i(marg), .lvl_o(p0_lv), .ttl_o(p0_tl));
  gpz_pin_board #(.W(8)) gpz_pin_board_inst1 (.clk_sys_i(clk_sys_i), .pin_o_i(p1_po),
    .pin_oe_i(p1_oe), .pullup_i(p1_pu), .drv_en_i(bd_en), .drv_val_i(bd_val),
    .marg_i({1'b0, marg}), .lvl_o(p1_lv), .ttl_o());
  // Port 2 has no pull-up on the board side of the device
  gpz_pin_board #(.W(8)) gpz_pin_board_inst2 (.clk_sys_i(clk_sys_i), .pin_o_i(p2_po),
    .pin_oe_i(p2_oe), .pullup_i(8'h00), .drv_en_i(bd_en), .drv_val_i(bd_val),
    .marg_i({1'b0, marg}), .lvl_o(p2_lv), .ttl_o());
  gpz_pin_board #(.W(2)) gpz_pin_board_inst3 (.clk_sys_i(clk_sys_i), .pin_o_i(p3_po),
    .pin_oe_i(p3_oe), .pullup_i(p3_pu), .drv_en_i(bd_en[1:0]), .drv_val_i(bd_val[1:0]),
    .marg_i(2'h0), .lvl_o(p3_lv), .ttl_o());

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One-cycle strobe; ends at the falling edge so outputs have settled
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk_sys_i);
    we <= 14'h0001 << sel;
    wdata <= d;
    @(posedge clk_sys_i);
    we <= 14'h0000;
    @(negedge clk_sys_i);
  endtask : wr

  // Board drive change, then settle
  task automatic bd(input logic [7:0] en, input logic [7:0] val, input logic [6:0] mg);
    @(posedge clk_sys_i);
    bd_en <= en;
    bd_val <= val;
    marg <= mg;
    @(negedge clk_sys_i);
  endtask : bd

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Reset held four cycles, then every port must be an undriven input
  task automatic rst();
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("p0_dir", 8'h7F, 8'(p0_dir));
    chk("p1_dir", 8'hFF, p1_dir);
    chk("p3_dir", 8'h03, 8'(p3_dir));
    chk("p2_dir", 8'hFF, p2_dir);
    chk("p2_acfg", 8'h00, p2_ac);
    chk("oe_all", 8'h00, 8'(p0_oe) | p1_oe | p2_oe | 8'(p3_oe));
  endtask : rst

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clk_sys_i);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    reset_i = 1'b1;
    we = '0;
    wdata = 8'h00;
    ch = 3'h0;
    bd_en = 8'h00;
    bd_val = 8'h00;
    marg = 7'h00;
    rst();
    // Timer and clock outputs are absent here, so the port-use prerequisites hold
    // Port 1: latch written while already an output, then read back
    wr(6, 8'h00);
    wr(5, 8'hA5);
    chk("p1_pin", 8'hA5, p1_po);
    chk("p1_oe", 8'hFF, p1_oe);
    chk("p1_rd", 8'hA5, p1_rd);
    bd(8'hFF, 8'h3C, 7'h00);
    wr(6, 8'h0F);
    chk("p1_dir_mix", 8'h0F, p1_dir);
    chk("p1_rd_mix", 8'hAC, p1_rd);
    bd(8'h00, 8'h00, 7'h00);
    wr(7, 8'hFF);
    chk("p1_pu", 8'h0F, p1_pu);
    chk("p1_rd_pu", 8'hAF, p1_rd);
    // Port 0: option bits only where they exist, open-drain drives low only
    wr(0, 8'h6B);
    wr(1, 8'h00);
    wr(4, 8'h7F);
    wr(3, 8'h7F);
    wr(2, 8'h7F);
    chk("p0_od", 8'h1C, 8'(p0_od));
    chk("p0_ibs", 8'h18, 8'(p0_ibs));
    chk("p0_ttl_buf", 8'h18, 8'(p0_tb));
    chk("p0_oe", 8'h77, 8'(p0_oe));
    chk("p0_pin", 8'h6B, 8'(p0_po));
    chk("p0_pu_out", 8'h00, 8'(p0_pu));
    bd(8'h7F, 8'h00, 7'h18);
    wr(1, 8'h7F);
    chk("p0_rd_ttl", 8'h18, 8'(p0_rd));
    chk("p0_pu_in", 8'h7F, 8'(p0_pu));
    // Port 2: digital input, digital output, analog and the forbidden mix
    bd(8'hFF, 8'h5A, 7'h00);
    chk("p2_rd_in", 8'h5A, p2_rd);
    wr(8, 8'hC3);
    wr(9, 8'hF0);
    wr(10, 8'hF0);
    chk("p2_acfg_an", 8'hF0, p2_ac);
    chk("p2_pin", 8'hC3, p2_po);
    chk("p2_oe", 8'h0F, p2_oe);
    chk("p2_path", 8'hF0, p2_ap);
    chk("p2_rd_an", 8'h03, p2_rd);
    chk("p2_err0", 8'h00, 8'(p2_er));
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys_i);
      ch <= 3'(i);
      @(negedge clk_sys_i);
      chk("p2_conv", 8'(i >= 4), 8'(p2_cv));
    end
    wr(9, 8'h00);
    chk("p2_err1", 8'h01, 8'(p2_er));
    chk("p2_oe_an", 8'h0F, p2_oe);
    // Port 3: drive, then pulled-up input
    bd(8'h00, 8'h00, 7'h00);
    wr(11, 8'h02);
    wr(12, 8'h00);
    chk("p3_pin", 8'h02, 8'(p3_po));
    chk("p3_oe", 8'h03, 8'(p3_oe));
    wr(12, 8'h03);
    wr(13, 8'h01);
    chk("p3_pu", 8'h01, 8'(p3_pu));
    chk("p3_rd_pu", 8'h01, 8'(p3_rd & 2'h1));
    // Reset in mid-run must restore inputs everywhere
    rst();
    end_sim();
  end
endmodule : gpz_ports_bench
